// >>> oag_core.sv
// Operand address generator with branch targets and direction registers
`timescale 1ns/100ps
`default_nettype none
module oag_core (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rstn,
    // Decoded instruction from the fetch logic
    input  wire logic            start,
    input  wire oag_pkg::oag_mode_t mode,
    input  wire logic [7:0]      opcode,
    input  wire logic [15:0]     opcode_addr,
    input  wire logic [7:0]      index_x,
    // Operand byte stream
    input  wire logic            op_valid,
    input  wire logic [7:0]      op_byte,
    // Tested memory byte for bit test
    input  wire logic [7:0]      test_byte,
    // Results
    output logic                 done,
    output logic [15:0]          eff_addr,
    output logic [1:0]           instr_len,
    output logic [15:0]          next_pc,
    output logic                 branch_taken,
    output logic                 carry_wr,
    output logic                 carry_val,
    output logic [2:0]           bit_num,
    output logic                 bit_set,
    // Memory-mapped direction registers
    input  wire logic            io_wr,
    input  wire logic            io_rd,
    input  wire logic [15:0]     io_addr,
    input  wire logic [7:0]      io_wdata,
    output logic [7:0]           io_rdata,
    output logic                 io_hit,
    output logic [7:0]           port_a_dir,
    output logic [7:0]           port_b_dir,
    output logic [7:0]           port_c_dir
);
    import oag_pkg::*;

    // ==========================================
    // Helpers
    function automatic logic [15:0] oag_rel(input logic [15:0] base, input logic [7:0] disp);
        oag_rel = base + {{8{disp[7]}}, disp};
    endfunction

    function automatic logic [1:0] oag_len(input oag_mode_t m);
        case (m)
            OAG_MODE_IX1, OAG_MODE_BSC, OAG_MODE_REL: oag_len = OAG_LEN_TWO;
            OAG_MODE_IX2, OAG_MODE_BTB:               oag_len = OAG_LEN_THREE;
            default:                                  oag_len = OAG_LEN_ONE;
        endcase
    endfunction

    // ==========================================
    // Operand collection
    oag_state_t  state_q, state_d;
    oag_mode_t   mode_q;
    logic [7:0]  opc_q, x_q, b1_q, b2_q;
    logic [15:0] pc0_q;
    logic [1:0]  need_q, cnt_q;

    wire logic [1:0] len_w   = oag_len(mode);
    wire logic [1:0] need_w  = len_w - 2'h1;
    wire logic       last_op = op_valid && (cnt_q + 2'h1 == need_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            OAG_ST_IDLE: if (start) state_d = (need_w == 2'h0) ? OAG_ST_DONE : OAG_ST_OPS;
            OAG_ST_OPS:  if (last_op) state_d = OAG_ST_DONE;
            OAG_ST_DONE: state_d = OAG_ST_IDLE;
            default:     state_d = OAG_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= OAG_ST_IDLE;
            mode_q  <= OAG_MODE_INH;
            opc_q   <= 8'h00;
            x_q     <= 8'h00;
            pc0_q   <= 16'h0000;
            need_q  <= 2'h0;
            cnt_q   <= 2'h0;
            b1_q    <= 8'h00;
            b2_q    <= 8'h00;
        end else begin
            state_q <= state_d;
            if (state_q == OAG_ST_IDLE && start) begin
                mode_q <= mode;
                opc_q  <= opcode;
                x_q    <= index_x;
                pc0_q  <= opcode_addr;
                need_q <= need_w;
                cnt_q  <= 2'h0;
            end else if (state_q == OAG_ST_OPS && op_valid) begin
                cnt_q <= cnt_q + 2'h1;
                if (cnt_q == 2'h0) b1_q <= op_byte;
                else               b2_q <= op_byte;
            end
        end
    end

    // ==========================================
    // Address and target computation
    wire logic [2:0]  bn_w      = opc_q[OAG_BITNUM_LSB +: 3];
    wire logic        pol_w     = opc_q[OAG_POL_BIT];
    wire logic        tbit_w    = test_byte[bn_w];
    // Bit test opcodes: low bit clear branches on set, set branches on clear
    wire logic        cond_w    = (tbit_w == ~pol_w);
    wire logic [15:0] ea_ix     = {8'h00, x_q};
    wire logic [15:0] ea_ix1    = {8'h00, x_q} + {8'h00, b1_q};
    wire logic [15:0] ea_ix2    = {8'h00, x_q} + {b1_q, b2_q};
    wire logic [15:0] ea_dir    = {8'h00, b1_q};
    wire logic [15:0] rel_tgt   = oag_rel(pc0_q + OAG_REL_BASE, b1_q);
    wire logic [15:0] btb_tgt   = oag_rel(pc0_q + OAG_BTB_BASE, b2_q);
    wire logic [15:0] seq_pc    = pc0_q + {14'h0000, oag_len(mode_q)};
    wire logic        is_btb    = (mode_q == OAG_MODE_BTB);

    logic [15:0] ea_sel;
    always_comb begin
        case (mode_q)
            OAG_MODE_IX:  ea_sel = ea_ix;
            OAG_MODE_IX1: ea_sel = ea_ix1;
            OAG_MODE_IX2: ea_sel = ea_ix2;
            OAG_MODE_BSC, OAG_MODE_BTB: ea_sel = ea_dir;
            default:      ea_sel = 16'h0000;
        endcase
    end

    // Outputs are registered one cycle after the last operand byte
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            done         <= 1'b0;
            eff_addr     <= 16'h0000;
            instr_len    <= 2'h0;
            next_pc      <= 16'h0000;
            branch_taken <= 1'b0;
            carry_wr     <= 1'b0;
            carry_val    <= 1'b0;
            bit_num      <= 3'h0;
            bit_set      <= 1'b0;
        end else begin
            done     <= (state_q == OAG_ST_DONE);
            carry_wr <= (state_q == OAG_ST_DONE) && is_btb;
            if (state_q == OAG_ST_DONE) begin
                eff_addr     <= ea_sel;
                instr_len    <= oag_len(mode_q);
                bit_num      <= bn_w;
                bit_set      <= ~pol_w;
                carry_val    <= is_btb ? tbit_w : carry_val;
                branch_taken <= is_btb ? cond_w : (mode_q == OAG_MODE_REL);
                if (is_btb && cond_w)              next_pc <= btb_tgt;
                else if (mode_q == OAG_MODE_REL)   next_pc <= rel_tgt;
                else                               next_pc <= seq_pc;
            end
        end
    end

    // ==========================================
    // Direction registers: write-only, reads return ones
    wire logic sel_a = (io_addr == OAG_PORT_A_DIRECTION_OFS);
    wire logic sel_b = (io_addr == OAG_PORT_B_DIRECTION_OFS);
    wire logic sel_c = (io_addr == OAG_PORT_C_DIRECTION_OFS);
    wire logic sel_any = sel_a || sel_b || sel_c;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            port_a_dir <= OAG_DIRECTION_RST;
            port_b_dir <= OAG_DIRECTION_RST;
            port_c_dir <= OAG_DIRECTION_RST;
            io_rdata   <= 8'h00;
            io_hit     <= 1'b0;
        end else begin
            if (io_wr && sel_a) port_a_dir <= io_wdata;
            if (io_wr && sel_b) port_b_dir <= io_wdata;
            if (io_wr && sel_c) port_c_dir <= io_wdata;
            // A read-modify-write here would set every other bit, hence whole-byte stores
            io_hit   <= io_rd && sel_any;
            io_rdata <= (io_rd && sel_any) ? OAG_DIRECTION_READ_VAL : 8'h00;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    one_byte_a: assert property (start && state_q == OAG_ST_IDLE && len_w == OAG_LEN_ONE
        |=> state_q == OAG_ST_DONE) else $error("one byte op fetched operands");
    ix_addr_a: assert property (done && mode_q == OAG_MODE_IX |-> eff_addr[15:8] == 8'h00)
        else $error("indexed address left low page");
    ix1_sum_a: assert property (state_q == OAG_ST_DONE && mode_q == OAG_MODE_IX1
        |=> eff_addr == {8'h00, x_q} + {8'h00, b1_q} && eff_addr <= 16'h01fe)
        else $error("indexed 8-bit sum wrong");
    ix2_sum_a: assert property (state_q == OAG_ST_DONE && mode_q == OAG_MODE_IX2
        |=> eff_addr == {8'h00, x_q} + {b1_q, b2_q}) else $error("indexed 16-bit sum wrong");
    bsc_len_a: assert property (done && mode_q == OAG_MODE_BSC
        |-> instr_len == 2'h2 && eff_addr[15:8] == 8'h00) else $error("bit op form wrong");
    dir_read_a: assert property (io_rd && sel_any |=> io_rdata == 8'hff && io_hit)
        else $error("direction read not ones");
    rel_span_a: assert property (state_q == OAG_ST_DONE && mode_q == OAG_MODE_REL
        |=> (next_pc - pc0_q) <= 16'h0081 || (pc0_q - next_pc) <= 16'h007e)
        else $error("relative span exceeded");
    btb_span_a: assert property (state_q == OAG_ST_DONE && is_btb && cond_w
        |=> (next_pc - pc0_q) <= 16'h0082 || (pc0_q - next_pc) <= 16'h007d)
        else $error("bit test span exceeded");
    btb_carry_a: assert property (state_q == OAG_ST_DONE && is_btb
        |=> carry_wr && carry_val == $past(tbit_w)) else $error("carry not copied");
    btb_not_a: assert property (state_q == OAG_ST_DONE && is_btb && !cond_w
        |=> next_pc == pc0_q + 16'h0003) else $error("untaken bit test pc wrong");
    inh_len_a: assert property (done && mode_q == OAG_MODE_INH |-> instr_len == 2'h1)
        else $error("inherent length wrong");

    cov_btb_c:  cover property (carry_wr && branch_taken);
    cov_ix2_c:  cover property (done && mode_q == OAG_MODE_IX2);
    cov_dir_c:  cover property (io_hit);
endmodule // oag_core
`default_nettype wire

// >>> oag_pkg.sv
// Package for the operand address generator: modes, register offsets and sizes
package oag_pkg;
    // ==========================================
    // Addressing modes
    typedef enum logic [2:0] {
        OAG_MODE_INH = 3'b000,
        OAG_MODE_REL = 3'b001,
        OAG_MODE_IX  = 3'b010,
        OAG_MODE_IX1 = 3'b011,
        OAG_MODE_IX2 = 3'b100,
        OAG_MODE_BSC = 3'b101,
        OAG_MODE_BTB = 3'b110
    } oag_mode_t;

    // ==========================================
    // Sequencer states
    typedef enum logic [1:0] {
        OAG_ST_IDLE = 2'b00,
        OAG_ST_OPS  = 2'b01,
        OAG_ST_DONE = 2'b10
    } oag_state_t;

    // ==========================================
    // Direction register offsets
    localparam logic [15:0] OAG_PORT_A_DIRECTION_OFS = 16'h0004;
    localparam logic [15:0] OAG_PORT_B_DIRECTION_OFS = 16'h0005;
    localparam logic [15:0] OAG_PORT_C_DIRECTION_OFS = 16'h0006;
    localparam logic [7:0]  OAG_DIRECTION_READ_VAL   = 8'hff;
    localparam logic [7:0]  OAG_DIRECTION_RST        = 8'h00;

    // ==========================================
    // Instruction lengths and branch offsets from the opcode address
    localparam logic [1:0]  OAG_LEN_ONE   = 2'h1;
    localparam logic [1:0]  OAG_LEN_TWO   = 2'h2;
    localparam logic [1:0]  OAG_LEN_THREE = 2'h3;
    localparam logic [15:0] OAG_REL_BASE  = 16'h0002;
    localparam logic [15:0] OAG_BTB_BASE  = 16'h0003;
    // Opcode fields: bit number [3:1], polarity/op in [0]
    localparam int          OAG_BITNUM_LSB = 1;
    localparam int          OAG_POL_BIT    = 0;
endpackage : oag_pkg

// >>> oag_mem_model.sv
// Memory model answering the byte stored at a direct address
`timescale 1ns/100ps
`default_nettype none
module oag_mem_model (
    // Direct address from the operand stream
    input  wire logic [7:0] addr,
    // Stored byte seen by the bit test
    output logic      [7:0] data
);
    // ==========================================
    // Storage
    logic [7:0] mem [256];
    // Fixed scrambled contents so every bit number meets both polarities
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 8'h5b + 8'h13);
    assign data = mem[addr];
endmodule // oag_mem_model
`default_nettype wire

// >>> test_operand_address_generator.sv
// Self-checking bench for the operand address generator
`timescale 1ns/100ps
`default_nettype none
module test_operand_address_generator;
    import oag_pkg::*;
    // ==========================================
    // Signals
    logic clk_sys = 0, rstn = 0, start = 0, op_valid = 0, io_wr = 0, io_rd = 0;
    oag_mode_t mode = OAG_MODE_INH;
    logic [7:0] opcode = 8'h00, index_x = 8'h00, op_byte = 8'h00, io_wdata = 8'h00;
    logic [7:0] tst_addr = 8'h00;
    logic [15:0] opcode_addr = 16'h0000, io_addr = 16'h0000;
    logic [7:0] test_byte, io_rdata, port_a_dir, port_b_dir, port_c_dir;
    logic done, branch_taken, carry_wr, carry_val, bit_set, io_hit;
    logic [15:0] eff_addr, next_pc;
    logic [1:0] instr_len;
    logic [2:0] bit_num;
    int miscompares = 0, checks = 0, seed = 32743;
    always #5 clk_sys = ~clk_sys;
    oag_core i_dut (.clk_sys, .rstn, .start, .mode, .opcode, .opcode_addr, .index_x,
        .op_valid, .op_byte, .test_byte, .done, .eff_addr, .instr_len, .next_pc,
        .branch_taken, .carry_wr, .carry_val, .bit_num, .bit_set, .io_wr, .io_rd,
        .io_addr, .io_wdata, .io_rdata, .io_hit, .port_a_dir, .port_b_dir, .port_c_dir);
    oag_mem_model i_mem (.addr(tst_addr), .data(test_byte));
    // ==========================================
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Byte the memory model holds at a direct address
    function automatic logic [7:0] mem_byte(input logic [7:0] a);
        mem_byte = 8'(a * 8'h5b + 8'h13);
    endfunction
    // Register access; a read is judged one cycle after it is taken
    task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d, exp_d,
                      input logic exp_hit);
        @(negedge clk_sys);
        io_wr = wr;
        io_rd = !wr;
        io_addr = a;
        io_wdata = d;
        @(negedge clk_sys);
        io_wr = 0;
        io_rd = 0;
        if (!wr) begin
            chk(io_rdata, exp_d);
            chk(io_hit, exp_hit);
        end
    endtask
    task automatic run(input oag_mode_t m, input logic [7:0] opc, x, b1, b2,
                       input logic [15:0] pc);
        logic [15:0] t;
        logic [15:0] len;
        logic [7:0] tb;
        logic bitv;
        int n;
        n = (m == OAG_MODE_IX2 || m == OAG_MODE_BTB) ? 2 :
            (m == OAG_MODE_INH || m == OAG_MODE_IX) ? 0 : 1;
        @(negedge clk_sys);
        start = 1;
        mode = m;
        opcode = opc;
        index_x = x;
        opcode_addr = pc;
        tst_addr = b1;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            start = 0;
            op_valid = 1;
            op_byte = i ? b2 : b1;
        end
        @(negedge clk_sys);
        start = 0;
        op_valid = 0;
        repeat (8) if (done !== 1'b1) @(negedge clk_sys);
        chk(done, 1'b1);
        len = (n == 0) ? 16'h1 : 16'(n + 1);
        tb = mem_byte(b1);
        bitv = tb[opc[3:1]];
        t = pc + len;
        if (m == OAG_MODE_REL) t = pc + 16'h2 + {{8{b1[7]}}, b1};
        if (m == OAG_MODE_BTB && bitv == !opc[0]) t = pc + 16'h3 + {{8{b2[7]}}, b2};
        chk(instr_len, len);
        chk(next_pc, t);
        if (m == OAG_MODE_REL) chk(branch_taken, 1'b1);
        if (m != OAG_MODE_REL && m != OAG_MODE_BTB) chk(branch_taken, 1'b0);
        if (m == OAG_MODE_BSC) chk(bit_set, !opc[0]);
        if (m == OAG_MODE_IX) chk(eff_addr, {8'h00, x});
        if (m == OAG_MODE_IX1) chk(eff_addr, 16'(x) + 16'(b1));
        if (m == OAG_MODE_IX2) chk(eff_addr, {b1, b2} + 16'(x));
        if (m == OAG_MODE_BSC || m == OAG_MODE_BTB) begin
            chk(eff_addr, {8'h00, b1});
            chk(bit_num, opc[3:1]);
        end
        if (m == OAG_MODE_BTB) begin
            chk(carry_wr, 1'b1);
            chk(carry_val, bitv);
            chk(branch_taken, bitv == !opc[0]);
        end
    endtask
    // ==========================================
    // Sequence
    initial begin
        repeat (6) @(negedge clk_sys);
        rstn = 1;
        chk(port_a_dir, OAG_DIRECTION_RST);
        // Span ends of both branch kinds and the 8-bit index sum at its limit
        run(OAG_MODE_REL, 8'h20, 8'h00, 8'h80, 8'h00, 16'h0400);
        run(OAG_MODE_REL, 8'h20, 8'h00, 8'h7f, 8'h00, 16'h0400);
        run(OAG_MODE_IX, 8'hf0, 8'hff, 8'h00, 8'h00, 16'h0100);
        run(OAG_MODE_IX1, 8'he0, 8'hff, 8'hff, 8'h00, 16'h0100);
        run(OAG_MODE_IX2, 8'hd0, 8'hff, 8'h12, 8'hf0, 16'h0100);
        run(OAG_MODE_BTB, 8'h0e, 8'h00, 8'h40, 8'h80, 16'h0300);
        run(OAG_MODE_BTB, 8'h05, 8'h00, 8'h40, 8'h7f, 16'h0300);
        run(OAG_MODE_BSC, 8'h1b, 8'h00, 8'h05, 8'h00, 16'h0200);
        run(OAG_MODE_INH, 8'h4f, 8'h00, 8'h00, 8'h00, 16'h0200);
        $display("test corners done");
        for (int k = 0; k < 80; k++) begin
            run(oag_mode_t'($unsigned($random(seed)) % 7), 8'($random(seed)),
                8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
                16'($random(seed)));
        end
        $display("test random done");
        // Direction bits are always written whole; a read shows all ones
        for (int p = 0; p < 3; p++) begin
            io(1'b1, OAG_PORT_A_DIRECTION_OFS + 16'(p), 8'h3c + 8'(p), 8'h00, 1'b0);
            io(1'b0, OAG_PORT_A_DIRECTION_OFS + 16'(p), 8'h00, OAG_DIRECTION_READ_VAL, 1'b1);
        end
        chk(port_a_dir, 8'h3c);
        chk(port_b_dir, 8'h3d);
        chk(port_c_dir, 8'h3e);
        io(1'b0, 16'h0007, 8'h00, 8'h00, 1'b0);
        io(1'b0, 16'h0003, 8'h00, 8'h00, 1'b0);
        $display("test registers done");
        test_done();
    end
    // Whole run needs well under ten microseconds
    initial begin
        #200000;
        miscompares++;
        test_done();
    end
endmodule // test_operand_address_generator
`default_nettype wire
